//--- hw/flash_cfg_pkg.sv
package flash_cfg_pkg;

  // ---------------------------------------------------------------
  // instruction codes
  // ---------------------------------------------------------------
  localparam logic [7:0] OP_WRITE_ENABLE  = 8'h06;
  localparam logic [7:0] OP_VOL_ENABLE    = 8'h50;
  localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] OP_READ_SR1      = 8'h05;
  localparam logic [7:0] OP_READ_SR2      = 8'h35;
  localparam logic [7:0] OP_READ_SR3      = 8'h15;
  localparam logic [7:0] OP_STREAM        = 8'h25;
  localparam logic [7:0] OP_WRITE_SR      = 8'h01;
  localparam logic [7:0] OP_WRITE_SR2     = 8'h31;
  localparam logic [7:0] OP_WRITE_SR3     = 8'h11;

  // ---------------------------------------------------------------
  // status field layout
  // ---------------------------------------------------------------
  localparam int SR1_BUSY_BIT = 0;
  localparam int SR1_WEL_BIT  = 1;
  localparam int SR1_STATUS_PROTECT_0_BIT = 7;
  localparam int SR2_STATUS_PROTECT_1_BIT = 0;
  localparam int SR2_SUSB_BIT = 2;
  localparam int SR2_SUSA_BIT = 7;

  localparam logic [7:0] SR1_WRITE_MASK = 8'hfc;
  localparam logic [7:0] SR2_WRITE_MASK = 8'h7b;
  localparam logic [7:0] SR3_WRITE_MASK = 8'h80;
  localparam logic [7:0] SR2_LOCK_MASK  = 8'h38;
  localparam logic [7:0] NO_LOCK_MASK   = 8'h00;

  localparam logic [7:0] SR1_RESET = 8'h00;
  localparam logic [7:0] SR2_RESET = 8'h00;
  localparam logic [7:0] SR3_RESET = 8'h00;

  // ---------------------------------------------------------------
  // frame lengths
  // ---------------------------------------------------------------
  localparam logic [2:0] OPCODE_LAST_BIT = 3'h7;
  localparam logic [4:0] ONE_BYTE_BITS   = 5'h08;
  localparam logic [4:0] TWO_BYTE_BITS   = 5'h10;
  localparam logic [4:0] DATA_CNT_MAX    = 5'h11;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS          = 20;
  localparam int STATUS_WRITE_TIME_NS   = 5000000;
  localparam int STATUS_WRITE_CYCLES    = STATUS_WRITE_TIME_NS / CLK_PERIOD_NS;

  typedef enum {
    ST_COMMAND,
    ST_CMD_DONE,
    ST_READ,
    ST_STREAM,
    ST_WDATA,
    ST_IGNORE
  } link_state_t;

endpackage

//--- hw/flash_status_config_cmds.sv
// Behaviour
// - 06h then select high sets write latch
// - 50h leaves latch, allows volatile 01h write
// - 04h clears the write enable latch
// - latch clears at reset and operation completion, unless a 06h frame completes in that same cycle
// - 05h/35h/15h read register 1/2/3, MSB first
// - status reads accepted even while busy
// - status read repeats until select rises
// - 25h streams live busy flag on output
// - streamed output only falls, never rises
// - select high ends stream, output released
// - 01h writes register 1, optionally register 2
// - 31h writes register 2, 11h register 3
// - only listed protect/config bits are writable
// - security lock bits are one-time settable
// - write never touches suspend, latch, busy
// - write only on 8/16 bit boundary
// - select rise starts timed non-volatile write, busy held
// - hardware protected mode blocks status writes
`timescale 1ns/1ps

module flash_status_config_cmds
  import flash_cfg_pkg::*;
#(
  parameter int WRITE_CYCLES = STATUS_WRITE_CYCLES
) (
  input  wire logic       CLK_IN,
  input  wire logic       SRST_IN,
  input  wire logic       CS_N_IN,
  input  wire logic       SCLK_IN,
  input  wire logic       SI_IN,
  input  wire logic       WP_N_IN,
  input  wire logic       OP_BUSY_IN,
  input  wire logic       WEL_CLEAR_IN,
  input  wire logic       SUSPEND_A_IN,
  input  wire logic       SUSPEND_B_IN,
  output logic            SO_OUT,
  output logic            SO_OE_OUT,
  output logic            WEL_OUT,
  output logic            BUSY_OUT,
  output logic            HW_PROTECT_OUT,
  output logic [7:0]      SR1_OUT,
  output logic [7:0]      SR2_OUT,
  output logic [7:0]      SR3_OUT
);

  localparam int TW = (WRITE_CYCLES > 1) ? $clog2(WRITE_CYCLES) : 1;

  if (WRITE_CYCLES < 1) begin : g_bad_cycles
    $error("WRITE_CYCLES must be at least one");
  end

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [7:0] merge_sr(input logic [7:0] old_v,
                                          input logic [7:0] data_v,
                                          input logic [7:0] mask_v,
                                          input logic [7:0] lock_v);
    merge_sr = ((old_v & ~mask_v) | (data_v & mask_v)) | (old_v & lock_v);
  endfunction

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [1:0] cs_sync_reg;
  logic [1:0] sclk_sync_reg;
  logic [1:0] si_sync_reg;
  logic [1:0] wp_sync_reg;
  logic       cs_d_reg;
  logic       sclk_d_reg;

  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      cs_sync_reg   <= 2'h3;
      sclk_sync_reg <= 2'h0;
      si_sync_reg   <= 2'h0;
      wp_sync_reg   <= 2'h3;
      cs_d_reg      <= 1'b1;
      sclk_d_reg    <= 1'b0;
    end else begin
      cs_sync_reg   <= {cs_sync_reg[0], CS_N_IN};
      sclk_sync_reg <= {sclk_sync_reg[0], SCLK_IN};
      si_sync_reg   <= {si_sync_reg[0], SI_IN};
      wp_sync_reg   <= {wp_sync_reg[0], WP_N_IN};
      cs_d_reg      <= cs_sync_reg[1];
      sclk_d_reg    <= sclk_sync_reg[1];
    end
  end

  logic cs_high;
  logic cs_rise;
  logic sclk_rise;
  logic sclk_fall;
  logic si_bit;

  assign cs_high   = cs_sync_reg[1];
  assign cs_rise   = cs_sync_reg[1] & ~cs_d_reg;
  assign sclk_rise = ~cs_high & sclk_sync_reg[1] & ~sclk_d_reg;
  assign sclk_fall = ~cs_high & ~sclk_sync_reg[1] & sclk_d_reg;
  assign si_bit    = si_sync_reg[1];

  // ---------------------------------------------------------------
  // status storage
  // ---------------------------------------------------------------
  logic [7:0] act1_reg;
  logic [7:0] act2_reg;
  logic [7:0] act3_reg;
  logic [7:0] nv1_reg;
  logic [7:0] nv2_reg;
  logic [7:0] nv3_reg;
  logic       wel_reg;
  logic       vol_en_reg;
  logic       wr_busy_reg;
  logic       busy;
  logic       hw_protected;
  logic [7:0] view1;
  logic [7:0] view2;
  logic [7:0] view3;

  assign busy = wr_busy_reg | OP_BUSY_IN;

  assign hw_protected = act2_reg[SR2_STATUS_PROTECT_1_BIT] | (act1_reg[SR1_STATUS_PROTECT_0_BIT] & ~wp_sync_reg[1]);

  always_comb begin
    view1 = act1_reg & SR1_WRITE_MASK;
    view1[SR1_BUSY_BIT] = busy;
    view1[SR1_WEL_BIT]  = wel_reg;
    view2 = act2_reg & SR2_WRITE_MASK;
    view2[SR2_SUSA_BIT] = SUSPEND_A_IN;
    view2[SR2_SUSB_BIT] = SUSPEND_B_IN;
    view3 = act3_reg & SR3_WRITE_MASK;
  end

  // ---------------------------------------------------------------
  // instruction framing
  // ---------------------------------------------------------------
  link_state_t state_reg;
  logic [7:0]  op_shift_reg;
  logic [2:0]  op_cnt_reg;
  logic [7:0]  opcode_reg;
  logic [7:0]  opcode_next;
  logic        op_complete;
  logic [15:0] data_shift_reg;
  logic [4:0]  data_cnt_reg;

  assign opcode_next = {op_shift_reg[6:0], si_bit};
  assign op_complete = (state_reg == ST_COMMAND) & sclk_rise & (op_cnt_reg == OPCODE_LAST_BIT);

  always_ff @(posedge CLK_IN) begin
    if (SRST_IN || cs_high) begin
      op_shift_reg <= 8'h00;
      op_cnt_reg   <= 3'h0;
    end else if (sclk_rise && state_reg == ST_COMMAND) begin
      op_shift_reg <= opcode_next;
      op_cnt_reg   <= op_cnt_reg + 3'h1;
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      opcode_reg <= 8'h00;
    end else if (op_complete) begin
      opcode_reg <= opcode_next;
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (SRST_IN || cs_high) begin
      state_reg <= ST_COMMAND;
    end else begin
      case (state_reg)
        ST_COMMAND: begin
          if (op_complete) begin
            case (opcode_next)
              OP_READ_SR1, OP_READ_SR2, OP_READ_SR3: state_reg <= ST_READ;
              OP_STREAM: state_reg <= ST_STREAM;
              OP_WRITE_SR, OP_WRITE_SR2, OP_WRITE_SR3: state_reg <= ST_WDATA;
              OP_WRITE_ENABLE, OP_WRITE_DISABLE, OP_VOL_ENABLE: state_reg <= ST_CMD_DONE;
              default: state_reg <= ST_IGNORE;
            endcase
          end
        end
        ST_CMD_DONE: begin
          if (sclk_rise) begin
            state_reg <= ST_IGNORE;
          end
        end
        default: begin
          state_reg <= state_reg;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // write data capture
  // ---------------------------------------------------------------
  always_ff @(posedge CLK_IN) begin
    if (SRST_IN || cs_high) begin
      data_shift_reg <= 16'h0000;
      data_cnt_reg   <= 5'h00;
    end else if (sclk_rise && state_reg == ST_WDATA) begin
      data_shift_reg <= {data_shift_reg[14:0], si_bit};
      if (data_cnt_reg != DATA_CNT_MAX) begin
        data_cnt_reg <= data_cnt_reg + 5'h01;
      end
    end
  end

  // ---------------------------------------------------------------
  // status write acceptance
  // ---------------------------------------------------------------
  logic       simple_done;
  logic       len_ok;
  logic       two_bytes;
  logic       wr_allowed;
  logic       wr_volatile;
  logic       wr_accept;
  logic [7:0] byte_a;
  logic [7:0] byte_b;
  logic [2:0] wr_sel;
  logic [7:0] new1;
  logic [7:0] new2;
  logic [7:0] new3;

  assign simple_done = cs_rise & (state_reg == ST_CMD_DONE);
  assign two_bytes   = (data_cnt_reg == TWO_BYTE_BITS) & (opcode_reg == OP_WRITE_SR);
  assign len_ok      = (data_cnt_reg == ONE_BYTE_BITS) | two_bytes;
  assign wr_volatile = vol_en_reg & (opcode_reg == OP_WRITE_SR);
  assign wr_allowed  = len_ok & ~busy & ~hw_protected & (wel_reg | wr_volatile);
  assign wr_accept   = cs_rise & (state_reg == ST_WDATA) & wr_allowed;
  assign byte_a      = two_bytes ? data_shift_reg[15:8] : data_shift_reg[7:0];
  assign byte_b      = data_shift_reg[7:0];

  always_comb begin
    wr_sel = 3'h0;
    new1   = wr_volatile ? act1_reg : nv1_reg;
    new2   = wr_volatile ? act2_reg : nv2_reg;
    new3   = wr_volatile ? act3_reg : nv3_reg;
    case (opcode_reg)
      OP_WRITE_SR: begin
        wr_sel[0] = 1'b1;
        new1 = merge_sr(new1, byte_a, SR1_WRITE_MASK, NO_LOCK_MASK);
        if (two_bytes) begin
          wr_sel[1] = 1'b1;
          // lock bits already set in the live copy survive a non-volatile write
          new2 = merge_sr(new2, byte_b | (act2_reg & SR2_LOCK_MASK), SR2_WRITE_MASK,
                          SR2_LOCK_MASK);
        end
      end
      OP_WRITE_SR2: begin
        wr_sel[1] = 1'b1;
        new2 = merge_sr(new2, byte_a | (act2_reg & SR2_LOCK_MASK), SR2_WRITE_MASK,
                        SR2_LOCK_MASK);
      end
      OP_WRITE_SR3: begin
        wr_sel[2] = 1'b1;
        new3 = merge_sr(new3, byte_a, SR3_WRITE_MASK, NO_LOCK_MASK);
      end
      default: begin
        wr_sel = 3'h0;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // self-timed write cycle
  // ---------------------------------------------------------------
  logic [TW-1:0] timer_reg;
  logic [7:0]    pend1_reg;
  logic [7:0]    pend2_reg;
  logic [7:0]    pend3_reg;
  logic [2:0]    pend_sel_reg;
  logic          wr_done;

  assign wr_done = wr_busy_reg & (timer_reg == '0);

  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      wr_busy_reg <= 1'b0;
      timer_reg   <= '0;
    end else if (wr_accept && !wr_volatile) begin
      wr_busy_reg <= 1'b1;
      timer_reg   <= TW'(WRITE_CYCLES - 1);
    end else if (wr_done) begin
      wr_busy_reg <= 1'b0;
    end else if (wr_busy_reg) begin
      timer_reg <= timer_reg - TW'(1);
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      pend1_reg    <= SR1_RESET;
      pend2_reg    <= SR2_RESET;
      pend3_reg    <= SR3_RESET;
      pend_sel_reg <= 3'h0;
    end else if (wr_accept && !wr_volatile) begin
      pend1_reg    <= new1;
      pend2_reg    <= new2;
      pend3_reg    <= new3;
      pend_sel_reg <= wr_sel;
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      nv1_reg <= SR1_RESET;
      nv2_reg <= SR2_RESET;
      nv3_reg <= SR3_RESET;
    end else if (wr_done) begin
      if (pend_sel_reg[0]) nv1_reg <= pend1_reg;
      if (pend_sel_reg[1]) nv2_reg <= pend2_reg;
      if (pend_sel_reg[2]) nv3_reg <= pend3_reg;
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      act1_reg <= SR1_RESET;
      act2_reg <= SR2_RESET;
      act3_reg <= SR3_RESET;
    end else if (wr_accept && wr_volatile) begin
      if (wr_sel[0]) act1_reg <= new1;
      if (wr_sel[1]) act2_reg <= new2;
    end else if (wr_done) begin
      if (pend_sel_reg[0]) act1_reg <= pend1_reg;
      if (pend_sel_reg[1]) act2_reg <= pend2_reg;
      if (pend_sel_reg[2]) act3_reg <= pend3_reg;
    end
  end

  // ---------------------------------------------------------------
  // write enable latch and volatile enable
  // ---------------------------------------------------------------
  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      wel_reg <= 1'b0;
    end else if (simple_done && opcode_reg == OP_WRITE_ENABLE) begin
      wel_reg <= 1'b1;
    end else if (wr_done || WEL_CLEAR_IN) begin
      wel_reg <= 1'b0;
    end else if (simple_done && opcode_reg == OP_WRITE_DISABLE) begin
      wel_reg <= 1'b0;
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      vol_en_reg <= 1'b0;
    end else if (cs_rise && state_reg != ST_COMMAND) begin
      vol_en_reg <= simple_done && (opcode_reg == OP_VOL_ENABLE);
    end
  end

  // ---------------------------------------------------------------
  // serial output
  // ---------------------------------------------------------------
  logic [7:0] rd_shift_reg;
  logic [2:0] rd_cnt_reg;
  logic [7:0] rd_view;

  always_comb begin
    rd_view = view1;
    if (opcode_reg == OP_READ_SR2) begin
      rd_view = view2;
    end else if (opcode_reg == OP_READ_SR3) begin
      rd_view = view3;
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (SRST_IN || cs_high) begin
      SO_OUT       <= 1'b0;
      SO_OE_OUT    <= 1'b0;
      rd_shift_reg <= 8'h00;
      rd_cnt_reg   <= 3'h0;
    end else if (op_complete) begin
      rd_cnt_reg <= 3'h0;
      if (opcode_next == OP_STREAM) begin
        SO_OUT    <= busy;
        SO_OE_OUT <= 1'b1;
      end else if (opcode_next == OP_READ_SR1 || opcode_next == OP_READ_SR2
                   || opcode_next == OP_READ_SR3) begin
        SO_OE_OUT <= 1'b1;
      end
    end else if (state_reg == ST_STREAM) begin
      SO_OUT <= SO_OUT & busy;
    end else if (state_reg == ST_READ && sclk_fall) begin
      rd_cnt_reg <= rd_cnt_reg + 3'h1;
      if (rd_cnt_reg == 3'h0) begin
        SO_OUT       <= rd_view[7];
        rd_shift_reg <= {rd_view[6:0], 1'b0};
      end else begin
        SO_OUT       <= rd_shift_reg[7];
        rd_shift_reg <= {rd_shift_reg[6:0], 1'b0};
      end
    end
  end

  // ---------------------------------------------------------------
  // status outputs
  // ---------------------------------------------------------------
  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      WEL_OUT        <= 1'b0;
      BUSY_OUT       <= 1'b0;
      HW_PROTECT_OUT <= 1'b0;
      SR1_OUT        <= SR1_RESET;
      SR2_OUT        <= SR2_RESET;
      SR3_OUT        <= SR3_RESET;
    end else begin
      WEL_OUT        <= wel_reg;
      BUSY_OUT       <= busy;
      HW_PROTECT_OUT <= hw_protected;
      SR1_OUT        <= view1;
      SR2_OUT        <= view2;
      SR3_OUT        <= view3;
    end
  end

endmodule // flash_status_config_cmds

//--- verification/flash_status_config_cmds_assertions.sv
`timescale 1ns/1ps
module flash_status_config_cmds_checker
  import flash_cfg_pkg::*;
#(
  parameter int WRITE_CYCLES = 20
) (
  input wire logic       CLK_IN,
  input wire logic       SRST_IN,
  input wire logic       CS_N_IN,
  input wire logic       SCLK_IN,
  input wire logic       SI_IN,
  input wire logic       WP_N_IN,
  input wire logic       OP_BUSY_IN,
  input wire logic       WEL_CLEAR_IN,
  input wire logic       SUSPEND_A_IN,
  input wire logic       SUSPEND_B_IN,
  input wire logic       SO_OUT,
  input wire logic       SO_OE_OUT,
  input wire logic       WEL_OUT,
  input wire logic       BUSY_OUT,
  input wire logic       HW_PROTECT_OUT,
  input wire logic [7:0] SR1_OUT,
  input wire logic [7:0] SR2_OUT,
  input wire logic [7:0] SR3_OUT
);
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (SRST_IN);

  // ---------------------------------------------------------------
  // busy length count, and busy caused by other logic
  // ---------------------------------------------------------------
  logic [19:0] busy_cnt;
  logic        ext_busy;

  always_ff @(posedge CLK_IN) begin
    if (SRST_IN || !BUSY_OUT) busy_cnt <= 20'h0;
    else busy_cnt <= busy_cnt + 20'h1;
  end

  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) ext_busy <= 1'h0;
    else if (OP_BUSY_IN) ext_busy <= 1'h1;
    else if (!BUSY_OUT) ext_busy <= 1'h0;
  end

  a_reset_quiet: assert property (disable iff (1'h0) $fell(SRST_IN) |->
    !SO_OE_OUT && !WEL_OUT && !BUSY_OUT && SR1_OUT == 8'h00 && SR3_OUT == 8'h00)
    else $error("outputs not idle after reset");
  a_idle_no_drive: assert property (CS_N_IN [*6] |-> !SO_OE_OUT)
    else $error("output driven while deselected");
  a_clear_pulse: assert property (CS_N_IN [*6] ##0 WEL_CLEAR_IN |=> ##[0:1] !WEL_OUT)
    else $error("latch not cleared by completion pulse");
  a_busy_cause: assert property ($rose(BUSY_OUT) |->
    $past(OP_BUSY_IN) || (CS_N_IN && $past(CS_N_IN)))
    else $error("busy rose inside a frame");
  a_busy_length: assert property ($fell(BUSY_OUT) && !ext_busy |->
    busy_cnt >= WRITE_CYCLES - 1 && busy_cnt <= WRITE_CYCLES + 1)
    else $error("write cycle length wrong");
  a_wel_write_end: assert property ($fell(BUSY_OUT) && !ext_busy |-> ##[0:1] !WEL_OUT)
    else $error("latch kept after write cycle");
  a_wel_in_frame: assert property ((!CS_N_IN) [*6] ##0 !WEL_CLEAR_IN && !BUSY_OUT
    |=> $stable(WEL_OUT))
    else $error("latch changed inside a frame");
  a_protect_mode: assert property (($stable(WP_N_IN) && $stable(SR1_OUT) && $stable(SR2_OUT)) [*6]
    |-> HW_PROTECT_OUT == (SR2_OUT[SR2_STATUS_PROTECT_1_BIT] | (SR1_OUT[SR1_STATUS_PROTECT_0_BIT] & !WP_N_IN)))
    else $error("protected mode flag wrong");
  a_sr3_readonly: assert property (SR3_OUT[6:0] == 7'h00)
    else $error("read-only register bits set");
  a_suspend_view: assert property (($stable(SUSPEND_A_IN)) [*3] |->
    SR2_OUT[SR2_SUSA_BIT] == SUSPEND_A_IN)
    else $error("suspend flag view wrong");
  a_lock_otp: assert property ((($past(SR2_OUT) & SR2_LOCK_MASK) & ~SR2_OUT) == 8'h00)
    else $error("lock bit cleared");

  c_write_done: cover property ($fell(BUSY_OUT) && !ext_busy);
  c_protected: cover property (HW_PROTECT_OUT);
  c_drive: cover property ($rose(SO_OE_OUT));
endmodule // flash_status_config_cmds_checker

bind flash_status_config_cmds flash_status_config_cmds_checker #(
  .WRITE_CYCLES(WRITE_CYCLES)
) u_checker (.CLK_IN(CLK_IN), .SRST_IN(SRST_IN), .CS_N_IN(CS_N_IN), .SCLK_IN(SCLK_IN),
  .SI_IN(SI_IN), .WP_N_IN(WP_N_IN), .OP_BUSY_IN(OP_BUSY_IN), .WEL_CLEAR_IN(WEL_CLEAR_IN),
  .SUSPEND_A_IN(SUSPEND_A_IN), .SUSPEND_B_IN(SUSPEND_B_IN), .SO_OUT(SO_OUT),
  .SO_OE_OUT(SO_OE_OUT), .WEL_OUT(WEL_OUT), .BUSY_OUT(BUSY_OUT),
  .HW_PROTECT_OUT(HW_PROTECT_OUT), .SR1_OUT(SR1_OUT), .SR2_OUT(SR2_OUT), .SR3_OUT(SR3_OUT));

//--- verification/spi_host_model.sv
`timescale 1ns/1ps
module spi_host_model #(
  parameter int HALF = 4
) (
  input  wire logic clk_in,
  output logic      cs_n_out,
  output logic      sclk_out,
  output logic      si_out,
  input  wire logic so_in
);
  logic [15:0] rd;

  initial begin
    cs_n_out = 1'h1;
    sclk_out = 1'h0;
    si_out = 1'h0;
  end

  // ---------------------------------------------------------------
  // one frame: opcode then nbits of data, msb first; keep holds select
  // ---------------------------------------------------------------
  task automatic frame(input logic [7:0] op, input int nbits, input logic [15:0] dat,
                       input logic keep);
    logic [23:0] sh;
    sh = {op, dat};
    rd = 16'h0;
    @(negedge clk_in);
    cs_n_out = 1'h0;
    repeat (HALF) @(negedge clk_in);
    for (int i = 0; i < 8 + nbits; i++) begin
      si_out = sh[23 - i];
      repeat (HALF) @(negedge clk_in);
      sclk_out = 1'h1;
      repeat (HALF) @(negedge clk_in);
      if (i >= 8) rd = {rd[14:0], so_in};
      sclk_out = 1'h0;
    end
    repeat (HALF) @(negedge clk_in);
    // select rises only at the bit count asked for
    if (!keep) cs_n_out = 1'h1;
    si_out = ~si_out;
    repeat (16) @(negedge clk_in);
  endtask

  task automatic release_cs();
    @(negedge clk_in);
    cs_n_out = 1'h1;
    repeat (16) @(negedge clk_in);
  endtask
endmodule // spi_host_model

//--- verification/test_flash_status_config_cmds.sv
`timescale 1ns/1ps
module test_flash_status_config_cmds;
  import flash_cfg_pkg::*;

  logic        clk, srst, wp_n, op_busy, wel_clr, sus_a, sus_b, wel_e;
  logic        cs_n, sclk, si, so, so_oe, write_enable_latch, busy, prot;
  logic [7:0]  sr1, sr2, sr3, sr1_e, sr2_e, sr3_e;
  logic [7:0]  rd_op[3];
  logic [7:0]  rd_v[3];
  logic [15:0] d, exp_q[$], got_q[$];
  string       name_q[$];
  int          fails, n_checks, cycles, seed = 32'hb7b1;

  initial begin
    clk = 1'h0;
    forever #10 clk = ~clk;
  end

  flash_status_config_cmds #(.WRITE_CYCLES(400)) dut (.CLK_IN(clk), .SRST_IN(srst),
    .CS_N_IN(cs_n), .SCLK_IN(sclk), .SI_IN(si), .WP_N_IN(wp_n), .OP_BUSY_IN(op_busy),
    .WEL_CLEAR_IN(wel_clr), .SUSPEND_A_IN(sus_a), .SUSPEND_B_IN(sus_b), .SO_OUT(so),
    .SO_OE_OUT(so_oe), .WEL_OUT(write_enable_latch), .BUSY_OUT(busy), .HW_PROTECT_OUT(prot),
    .SR1_OUT(sr1), .SR2_OUT(sr2), .SR3_OUT(sr3));

  spi_host_model host (.clk_in(clk), .cs_n_out(cs_n), .sclk_out(sclk), .si_out(si),
    .so_in(so));

  // ---------------------------------------------------------------
  // checking helpers
  // ---------------------------------------------------------------
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic compare_val(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic note(input string nm, input logic [15:0] e, input logic [15:0] g);
    name_q.push_back(nm);
    exp_q.push_back(e);
    got_q.push_back(g);
  endtask

  initial forever begin
    wait (got_q.size() > 0);
    compare_val(name_q.pop_front(), exp_q.pop_front(), got_q.pop_front());
  end

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      fails++;
      stop_test();
    end
  end

  function automatic logic [7:0] view2();
    return sr2_e | {sus_a, 4'h0, sus_b, 2'h0};
  endfunction

  function automatic logic [7:0] merge2(input logic [7:0] x);
    return (x & SR2_WRITE_MASK & ~SR2_LOCK_MASK) | ((x | sr2_e) & SR2_LOCK_MASK);
  endfunction

  task automatic chk_all();
    @(negedge clk);
    note("wel", {15'h0, wel_e}, {15'h0, write_enable_latch});
    note("busy", 16'h0, {15'h0, busy});
    note("sr1", {8'h0, sr1_e[7:2], wel_e, 1'h0}, {8'h0, sr1});
    note("sr2", {8'h0, view2()}, {8'h0, sr2});
    note("sr3", {8'h0, sr3_e}, {8'h0, sr3});
    note("prot", {15'h0, sr1_e[7] & ~wp_n}, {15'h0, prot});
  endtask

  task automatic cmd(input logic [7:0] op);
    host.frame(op, 0, 16'h0, 1'h0);
  endtask

  task automatic nv_write(input logic [7:0] op, input logic [7:0] dat);
    int k;
    cmd(OP_WRITE_ENABLE);
    host.frame(op, 8, {dat, 8'h0}, 1'h0);
    note("busy_on", 16'h1, {15'h0, busy});
    host.frame(OP_READ_SR1, 16, 16'h0, 1'h0);
    note("busy_rd", {2{sr1_e[7:2], 2'h3}}, host.rd);
    for (k = 0; k < 1000 && busy !== 1'h0; k++) @(negedge clk);
    wel_e = 1'h0;
  endtask

  initial begin
    srst = 1'h1;
    wp_n = 1'h1;
    op_busy = 1'h0;
    wel_clr = 1'h0;
    sus_a = 1'($random(seed));
    sus_b = 1'($random(seed));
    {sr1_e, sr2_e, sr3_e, wel_e} = 25'h0;
    rd_op = '{OP_READ_SR1, OP_READ_SR2, OP_READ_SR3};
    repeat (2) @(negedge clk);
    srst = 1'h0;
    repeat (6) @(negedge clk);
    chk_all();
    cmd(OP_WRITE_ENABLE);
    wel_e = 1'h1;
    chk_all();
    cmd(OP_WRITE_DISABLE);
    wel_e = 1'h0;
    chk_all();
    repeat (3) begin
      cmd(OP_VOL_ENABLE);
      chk_all();
      d = 16'($random(seed)) & 16'hfffe;
      host.frame(OP_WRITE_SR, 16, d, 1'h0);
      sr1_e = d[15:8] & SR1_WRITE_MASK;
      sr2_e = merge2(d[7:0]);
      chk_all();
    end
    rd_v = '{{sr1_e[7:2], 2'h0}, view2(), sr3_e};
    foreach (rd_op[i]) begin
      host.frame(rd_op[i], 16, 16'($random(seed)), 1'h0);
      note("read", {rd_v[i], rd_v[i]}, host.rd);
    end
    d = 16'($random(seed)) & 16'hfffe;
    nv_write(OP_WRITE_SR2, d[7:0]);
    sr2_e = merge2(d[7:0]);
    chk_all();
    nv_write(OP_WRITE_SR3, d[15:8]);
    sr3_e = d[15:8] & SR3_WRITE_MASK;
    chk_all();
    nv_write(OP_WRITE_SR, d[15:8]);
    sr1_e = d[15:8] & SR1_WRITE_MASK;
    chk_all();
    cmd(OP_WRITE_ENABLE);
    host.frame(OP_WRITE_SR, 12, ~d, 1'h0);
    wel_e = 1'h1;
    chk_all();
    cmd(OP_WRITE_DISABLE);
    host.frame(OP_WRITE_SR, 8, ~d, 1'h0);
    wel_e = 1'h0;
    chk_all();
    cmd(OP_WRITE_ENABLE);
    wel_clr = 1'h1;
    @(negedge clk);
    wel_clr = 1'h0;
    chk_all();
    op_busy = 1'h1;
    host.frame(OP_STREAM, 0, 16'h0, 1'h1);
    repeat (8) @(negedge clk);
    note("so_on", 16'h3, {14'h0, so_oe, so});
    op_busy = 1'h0;
    repeat (8) @(negedge clk);
    note("so_fall", 16'h2, {14'h0, so_oe, so});
    op_busy = 1'h1;
    repeat (8) @(negedge clk);
    note("so_low", 16'h2, {14'h0, so_oe, so});
    op_busy = 1'h0;
    host.release_cs();
    note("so_off", 16'h0, {15'h0, so_oe});
    wp_n = 1'h0;
    cmd(OP_VOL_ENABLE);
    host.frame(OP_WRITE_SR, 8, 16'h8000, 1'h0);
    // refused when protect0 is already set with the pin low
    if (!sr1_e[7]) sr1_e = 8'h80;
    chk_all();
    cmd(OP_VOL_ENABLE);
    host.frame(OP_WRITE_SR, 8, 16'h0400, 1'h0);
    chk_all();
    wp_n = 1'h1;
    repeat (8) @(negedge clk);
    chk_all();
    wait (got_q.size() == 0);
    #1;
    stop_test();
  end
endmodule // test_flash_status_config_cmds
